/* File: peg_pkg.sv */
package peg_pkg;

  typedef enum logic [1:0] {
    PEG_ACT_STOP_NOW = 2'b00,
    PEG_ACT_STOP_END = 2'b01,
    PEG_ACT_ADJ_STOP = 2'b10,
    PEG_ACT_ADJ_ONLY = 2'b11
  } peg_act_e;

  typedef enum logic [1:0] {
    PEG_IDLE = 2'b00,
    PEG_WAIT_END = 2'b01,
    PEG_ADJUST = 2'b10
  } peg_state_e;

  typedef enum logic [2:0] {
    PEG_JIT_SW_COUNT = 3'b000,
    PEG_JIT_SW_APPROACH = 3'b001,
    PEG_JIT_HW_COUNT_APPROACH = 3'b010,
    PEG_JIT_HW_FULL_APPROACH = 3'b011,
    PEG_JIT_HW_PARTIAL = 3'b100
  } peg_jit_e;

  typedef struct packed {
    logic soft_trigger_bit;
    logic soft_trigger_enable;
    logic follow_trigger_stop;
    logic jitter_hw_select;
    logic jitter_method_select;
    logic jitter_hw_submode;
  } peg_ctrl_s;

  typedef struct packed {
    logic no_phase_flag;
    logic short_phase_flag;
    logic forced_off_flag;
    logic auto_adjust_flag;
  } peg_flag_s;

endpackage

/* File: peg_protect.sv */
`timescale 1ns/100ps
`include "peg_regs.svh"

module peg_protect #(
  parameter int PW = `PEG_PERIOD_W,
  parameter int MW = `PEG_PHASE_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic second_drive_out,
  input wire logic phase_in,
  input wire logic period_end,
  input wire logic comparator1_out,
  input wire logic [6:0] comparator2_to_8_outs,
  output logic phase_guard_event,
  output logic error_guard_irq,
  output logic generator_on,
  output logic mask_select_a,
  output logic mask_select_b,
  output logic mask_level_a,
  output logic mask_level_b,
  output logic [PW-1:0] period_value,
  output logic [PW-1:0] duty_value,
  output logic auto_adjust_active,
  output logic jitter_enable,
  output peg_pkg::peg_jit_e jitter_mode,
  output logic jitter_timer_use
);

  if (PW < 4 || PW > 16) begin : g_bad_pw
    $error("period width must be 4 to 16");
  end
  if (MW < 2 || MW > 16) begin : g_bad_mw
    $error("phase width must be 2 to 16");
  end

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // {valid, code}: lowest action code among active sources
  function automatic logic [2:0] best_code(input logic [8:0] v,
                                           input logic [17:0] f);
    logic [2:0] r;
    r = {1'b0, 2'b11};
    for (int i = 0; i < `PEG_NUM_SRC; i++) begin
      if (v[i] && (!r[2] || f[2*i +: 2] < r[1:0])) begin
        r = {1'b1, f[2*i +: 2]};
      end
    end
    return r;
  endfunction

  // lowest active source running the given code
  function automatic logic [3:0] first_src(input logic [8:0] v,
                                           input logic [17:0] f,
                                           input logic [1:0] c);
    logic [3:0] r;
    r = 4'hf;
    for (int i = `PEG_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i] && f[2*i +: 2] == c) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic wr_go;
  logic [31:0] rd_mux;
  peg_pkg::peg_ctrl_s ctrl;
  peg_pkg::peg_flag_s flags;
  logic [7:0] error_guard_enables;
  logic [`PEG_ACT_W-1:0] action_select;
  logic [PW-1:0] period_floor;
  logic [PW-1:0] period_step;
  logic [MW-1:0] min_phase_width;
  peg_pkg::peg_state_e state;

  assign wr_go = avs_write & ~avs_waitrequest;

  function automatic logic wr_at(input logic go, input logic [5:0] a,
                                 input logic [5:0] off);
    return go && a == off;
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  always_comb begin
    rd_mux = 32'h0;
    case (avs_address)
      `PEG_OFF_CTRL: begin
        rd_mux[`PEG_CTRL_GEN_ON] = generator_on;
        rd_mux[`PEG_CTRL_MASK_SEL_A] = mask_select_a;
        rd_mux[`PEG_CTRL_MASK_SEL_B] = mask_select_b;
        rd_mux[`PEG_CTRL_MASK_LVL_A] = mask_level_a;
        rd_mux[`PEG_CTRL_MASK_LVL_B] = mask_level_b;
        rd_mux[`PEG_CTRL_SOFT_BIT] = ctrl.soft_trigger_bit;
        rd_mux[`PEG_CTRL_SOFT_EN] = ctrl.soft_trigger_enable;
        rd_mux[`PEG_CTRL_FOLLOW] = ctrl.follow_trigger_stop;
        rd_mux[`PEG_CTRL_JIT_EN] = jitter_enable;
        rd_mux[`PEG_CTRL_JIT_HW] = ctrl.jitter_hw_select;
        rd_mux[`PEG_CTRL_JIT_METHOD] = ctrl.jitter_method_select;
        rd_mux[`PEG_CTRL_JIT_SUB] = ctrl.jitter_hw_submode;
      end
      `PEG_OFF_STATUS: begin
        rd_mux[`PEG_ST_NO_PHASE] = flags.no_phase_flag;
        rd_mux[`PEG_ST_SHORT_PHASE] = flags.short_phase_flag;
        rd_mux[`PEG_ST_FORCED_OFF] = flags.forced_off_flag;
        rd_mux[`PEG_ST_AUTO_ADJ] = flags.auto_adjust_flag;
        rd_mux[`PEG_ST_IRQ] = error_guard_irq;
        rd_mux[`PEG_ST_BUSY] = state != peg_pkg::PEG_IDLE;
      end
      `PEG_OFF_ENABLES: rd_mux[7:0] = error_guard_enables;
      `PEG_OFF_ACTION: rd_mux[`PEG_ACT_W-1:0] = action_select;
      `PEG_OFF_PERIOD: rd_mux[PW-1:0] = period_value;
      `PEG_OFF_DUTY: rd_mux[PW-1:0] = duty_value;
      `PEG_OFF_FLOOR: rd_mux[PW-1:0] = period_floor;
      `PEG_OFF_STEP: rd_mux[PW-1:0] = period_step;
      `PEG_OFF_MIN_PHASE: rd_mux[MW-1:0] = min_phase_width;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // plain configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= '0;
      mask_level_a <= 1'b0;
      mask_level_b <= 1'b0;
      error_guard_enables <= 8'h00;
      action_select <= '0;
      min_phase_width <= `PEG_RST_MIN_PHASE;
    end else begin
      if (wr_at(wr_go, avs_address, `PEG_OFF_CTRL)) begin
        ctrl.soft_trigger_bit <= avs_writedata[`PEG_CTRL_SOFT_BIT];
        ctrl.soft_trigger_enable <= avs_writedata[`PEG_CTRL_SOFT_EN];
        ctrl.follow_trigger_stop <= avs_writedata[`PEG_CTRL_FOLLOW];
        ctrl.jitter_hw_select <= avs_writedata[`PEG_CTRL_JIT_HW];
        ctrl.jitter_method_select <= avs_writedata[`PEG_CTRL_JIT_METHOD];
        ctrl.jitter_hw_submode <= avs_writedata[`PEG_CTRL_JIT_SUB];
        mask_level_a <= avs_writedata[`PEG_CTRL_MASK_LVL_A];
        mask_level_b <= avs_writedata[`PEG_CTRL_MASK_LVL_B];
      end
      if (wr_at(wr_go, avs_address, `PEG_OFF_ENABLES)) begin
        error_guard_enables <= avs_writedata[7:0];
      end
      if (wr_at(wr_go, avs_address, `PEG_OFF_ACTION)) begin
        action_select <= avs_writedata[`PEG_ACT_W-1:0];
      end
      if (wr_at(wr_go, avs_address, `PEG_OFF_MIN_PHASE)) begin
        min_phase_width <= avs_writedata[MW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // phase protect detection
  // ---------------------------------------------------------------
  logic trig_d;
  logic phase_d;
  logic armed;
  logic seen;
  logic measuring;
  logic [MW-1:0] width;
  logic trig_rise;
  logic no_hit;
  logic short_hit;

  assign trig_rise = second_drive_out & ~trig_d;
  assign no_hit = trig_rise & armed & ~seen & ~comparator1_out;
  assign short_hit = measuring & (~phase_in | trig_rise)
                     & (width < min_phase_width);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      trig_d <= 1'b0;
      phase_d <= 1'b0;
      armed <= 1'b0;
      seen <= 1'b0;
      measuring <= 1'b0;
      width <= '0;
    end else begin
      trig_d <= second_drive_out;
      phase_d <= phase_in;
      if (trig_rise) begin
        armed <= 1'b1;
        seen <= 1'b0;
        measuring <= 1'b0;
        width <= '0;
      end else if (phase_in && !phase_d && !seen) begin
        seen <= 1'b1;
        measuring <= 1'b1;
        width <= MW'(1);
      end else if (measuring) begin
        if (!phase_in) begin
          measuring <= 1'b0;
        end else if (width != '1) begin
          width <= width + MW'(1);
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_guard_event <= 1'b0;
    end else begin
      phase_guard_event <= no_hit | short_hit;
    end
  end

  // ---------------------------------------------------------------
  // error sources and interrupt
  // ---------------------------------------------------------------
  logic [8:0] src;
  logic [8:0] act;
  logic [8:0] act_d;
  logic [17:0] fields;
  logic [17:0] held;
  logic [2:0] best;
  logic [2:0] best_new;

  assign src = {ctrl.soft_trigger_bit, comparator2_to_8_outs,
                phase_guard_event};
  assign act = src & {ctrl.soft_trigger_enable, error_guard_enables};
  assign fields = (state == peg_pkg::PEG_IDLE) ?
                  action_select[17:0] : held;
  assign best = best_code(act, fields);
  assign best_new = best_code(act & ~act_d, fields);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      error_guard_irq <= 1'b0;
      act_d <= '0;
      held <= '0;
    end else begin
      error_guard_irq <= |act;
      act_d <= act;
      if (state == peg_pkg::PEG_IDLE) begin
        held <= action_select[17:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // protect action sequencer
  // ---------------------------------------------------------------
  peg_pkg::peg_state_e next_state;
  peg_pkg::peg_act_e cur_code;
  peg_pkg::peg_act_e next_code;
  logic [3:0] trig_idx;
  logic do_shut;
  logic do_step;
  logic start_adj;
  logic can_step;
  logic stop_req;
  logic release_hit;

  assign can_step = ({1'b0, period_value} >= {1'b0, period_step})
                    && (period_value - period_step >= period_floor);
  assign release_hit = cur_code == peg_pkg::PEG_ACT_ADJ_ONLY
                       && ctrl.follow_trigger_stop
                       && (trig_idx == `PEG_FOLLOW_SRC_A
                           || trig_idx == `PEG_FOLLOW_SRC_B)
                       && !src[trig_idx];
  assign stop_req = release_hit
                    || (wr_at(wr_go, avs_address, `PEG_OFF_STATUS)
                        && avs_writedata[`PEG_ST_AUTO_ADJ]);

  always_comb begin
    next_state = state;
    next_code = cur_code;
    do_shut = 1'b0;
    do_step = 1'b0;
    start_adj = 1'b0;
    case (state)
      peg_pkg::PEG_IDLE: begin
        if (best_new[2]) begin
          case (best_new[1:0])
            peg_pkg::PEG_ACT_STOP_NOW: do_shut = 1'b1;
            peg_pkg::PEG_ACT_STOP_END: next_state = peg_pkg::PEG_WAIT_END;
            default: begin
              next_state = peg_pkg::PEG_ADJUST;
              next_code = peg_pkg::peg_act_e'(best_new[1:0]);
              start_adj = 1'b1;
            end
          endcase
        end
      end
      peg_pkg::PEG_WAIT_END: begin
        if ((best[2] && best[1:0] == peg_pkg::PEG_ACT_STOP_NOW)
            || period_end) begin
          do_shut = 1'b1;
          next_state = peg_pkg::PEG_IDLE;
        end
      end
      peg_pkg::PEG_ADJUST: begin
        if (best[2] && best[1:0] == peg_pkg::PEG_ACT_STOP_NOW) begin
          do_shut = 1'b1;
          next_state = peg_pkg::PEG_IDLE;
        end else if (best[2] && best[1:0] == peg_pkg::PEG_ACT_STOP_END) begin
          next_state = peg_pkg::PEG_WAIT_END;
        end else if (stop_req) begin
          next_state = (cur_code == peg_pkg::PEG_ACT_ADJ_STOP) ?
                       peg_pkg::PEG_WAIT_END : peg_pkg::PEG_IDLE;
        end else begin
          if (best[2] && best[1:0] == peg_pkg::PEG_ACT_ADJ_STOP) begin
            next_code = peg_pkg::PEG_ACT_ADJ_STOP;
          end
          if (period_end) begin
            if (can_step) begin
              do_step = 1'b1;
            end else begin
              next_state = peg_pkg::PEG_IDLE;
              do_shut = next_code == peg_pkg::PEG_ACT_ADJ_STOP;
            end
          end
        end
      end
      default: next_state = peg_pkg::PEG_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= peg_pkg::PEG_IDLE;
      cur_code <= peg_pkg::PEG_ACT_STOP_NOW;
      trig_idx <= 4'hf;
      auto_adjust_active <= 1'b0;
    end else begin
      state <= next_state;
      cur_code <= next_code;
      auto_adjust_active <= next_state == peg_pkg::PEG_ADJUST;
      if (start_adj) begin
        trig_idx <= first_src(act & ~act_d, fields, best_new[1:0]);
      end
    end
  end

  // ---------------------------------------------------------------
  // period and duty registers
  // ---------------------------------------------------------------
  logic wr_open;

  assign wr_open = wr_go && state != peg_pkg::PEG_ADJUST;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      period_value <= PW'(`PEG_RST_PERIOD);
      duty_value <= PW'(`PEG_RST_DUTY);
      period_floor <= '0;
      period_step <= '0;
    end else begin
      if (do_step) begin
        period_value <= period_value - period_step;
        duty_value <= (duty_value > (period_step >> 1)) ?
                      duty_value - (period_step >> 1) : '0;
      end else begin
        if (wr_open && avs_address == `PEG_OFF_PERIOD) begin
          period_value <= avs_writedata[PW-1:0];
        end
        if (wr_open && avs_address == `PEG_OFF_DUTY) begin
          duty_value <= avs_writedata[PW-1:0];
        end
      end
      if (wr_open && avs_address == `PEG_OFF_FLOOR) begin
        period_floor <= avs_writedata[PW-1:0];
      end
      if (wr_open && avs_address == `PEG_OFF_STEP) begin
        period_step <= avs_writedata[PW-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // generator control and status flags
  // ---------------------------------------------------------------
  logic wr_ctrl;
  logic wr_st;

  assign wr_ctrl = wr_at(wr_go, avs_address, `PEG_OFF_CTRL);
  assign wr_st = wr_at(wr_go, avs_address, `PEG_OFF_STATUS);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      generator_on <= 1'b0;
      mask_select_a <= 1'b0;
      mask_select_b <= 1'b0;
    end else if (do_shut) begin
      generator_on <= 1'b0;
      mask_select_a <= 1'b1;
      mask_select_b <= 1'b1;
    end else if (wr_ctrl) begin
      generator_on <= avs_writedata[`PEG_CTRL_GEN_ON];
      mask_select_a <= avs_writedata[`PEG_CTRL_MASK_SEL_A];
      mask_select_b <= avs_writedata[`PEG_CTRL_MASK_SEL_B];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flags <= '0;
    end else begin
      flags.no_phase_flag <= no_hit | (flags.no_phase_flag
          & ~(wr_st & avs_writedata[`PEG_ST_NO_PHASE]));
      flags.short_phase_flag <= short_hit | (flags.short_phase_flag
          & ~(wr_st & avs_writedata[`PEG_ST_SHORT_PHASE]));
      flags.forced_off_flag <= do_shut | (flags.forced_off_flag
          & ~(wr_st & avs_writedata[`PEG_ST_FORCED_OFF]));
      if (start_adj) begin
        flags.auto_adjust_flag <= 1'b1;
      end else if (wr_st) begin
        flags.auto_adjust_flag <= avs_writedata[`PEG_ST_AUTO_ADJ];
      end
    end
  end

  // ---------------------------------------------------------------
  // frequency jitter mode select
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      jitter_enable <= 1'b0;
    end else if (error_guard_irq || flags.auto_adjust_flag
                 || auto_adjust_active) begin
      jitter_enable <= 1'b0;
    end else if (wr_ctrl) begin
      jitter_enable <= avs_writedata[`PEG_CTRL_JIT_EN];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      jitter_mode <= peg_pkg::PEG_JIT_SW_COUNT;
      jitter_timer_use <= 1'b0;
    end else begin
      jitter_timer_use <= ctrl.jitter_hw_select;
      if (!ctrl.jitter_hw_select) begin
        jitter_mode <= ctrl.jitter_method_select ?
                       peg_pkg::PEG_JIT_SW_APPROACH :
                       peg_pkg::PEG_JIT_SW_COUNT;
      end else if (!ctrl.jitter_hw_submode) begin
        jitter_mode <= ctrl.jitter_method_select ?
                       peg_pkg::PEG_JIT_HW_FULL_APPROACH :
                       peg_pkg::PEG_JIT_HW_COUNT_APPROACH;
      end else begin
        jitter_mode <= peg_pkg::PEG_JIT_HW_PARTIAL;
      end
    end
  end

endmodule

/* File: peg_protect_sva.sv */
`timescale 1ns/100ps
module peg_protect_sva #(
  parameter int PW = 12
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic period_end,
  input wire logic phase_guard_event,
  input wire logic error_guard_irq,
  input wire logic generator_on,
  input wire logic mask_select_a,
  input wire logic mask_select_b,
  input wire logic [PW-1:0] period_value,
  input wire logic [PW-1:0] duty_value,
  input wire logic auto_adjust_active,
  input wire logic jitter_enable,
  input wire peg_pkg::peg_jit_e jitter_mode,
  input wire logic jitter_timer_use
);
  logic wr_land;
  assign wr_land = avs_write & ~avs_waitrequest;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  function automatic logic [PW-1:0] less_half(logic [PW-1:0] d,
                                              logic [PW-1:0] s);
    return (d > (s >> 1)) ? d - (s >> 1) : '0;
  endfunction
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not answered in one cycle");
  a_wait_back: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_event_pulse: assert property (phase_guard_event |=> !phase_guard_event)
    else $error("phase event longer than one cycle");
  a_period_edge: assert property ($changed(period_value) && !$past(wr_land)
    |-> $past(period_end)) else $error("period changed off boundary");
  a_duty_half: assert property (
    !$past(wr_land) && period_value < $past(period_value) |-> duty_value ==
    less_half($past(duty_value), $past(period_value) - period_value))
    else $error("duty not reduced by half step");
  a_off_masks: assert property ($fell(generator_on) && !$past(wr_land)
    |-> mask_select_a && mask_select_b) else $error("shutdown unmasked");
  a_off_holds: assert property (!generator_on && !wr_land |=> !generator_on)
    else $error("generator restarted without write");
  a_jit_clear: assert property (error_guard_irq || auto_adjust_active
    |=> !jitter_enable) else $error("jitter left enabled");
  a_timer_mode: assert property (
    $stable(jitter_mode) && $stable(jitter_timer_use) |->
    jitter_timer_use == (jitter_mode[2] | jitter_mode[1]))
    else $error("section timer use disagrees with mode");
endmodule

bind peg_protect peg_protect_sva #(.PW(PW)) i_sva (.mclk(mclk),
  .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .period_end(period_end),
  .phase_guard_event(phase_guard_event), .error_guard_irq(error_guard_irq),
  .generator_on(generator_on), .mask_select_a(mask_select_a),
  .mask_select_b(mask_select_b), .period_value(period_value),
  .duty_value(duty_value), .auto_adjust_active(auto_adjust_active),
  .jitter_enable(jitter_enable), .jitter_mode(jitter_mode),
  .jitter_timer_use(jitter_timer_use));

/* File: peg_protect_tb.sv */
`timescale 1ns/100ps
`include "peg_regs.svh"
module peg_protect_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rq;
  logic avs_waitrequest;
  logic comparator1_out = 1'b0;
  logic [6:0] comparator2_to_8_outs = '0;
  logic [5:0] phw = '0;
  logic second_drive_out, phase_in, period_end, phase_guard_event;
  logic error_guard_irq, generator_on, mask_select_a, mask_select_b;
  logic mask_level_a, mask_level_b, auto_adjust_active, jitter_enable;
  logic jitter_timer_use;
  logic [11:0] period_value, duty_value;
  peg_pkg::peg_jit_e jitter_mode;
  int errors = 0;
  int tests_run = 0;
  always #4 mclk = ~mclk;
  peg_protect i_dut (.mclk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .second_drive_out,
    .phase_in, .period_end, .comparator1_out, .comparator2_to_8_outs,
    .phase_guard_event, .error_guard_irq, .generator_on, .mask_select_a,
    .mask_select_b, .mask_level_a, .mask_level_b, .period_value,
    .duty_value, .auto_adjust_active, .jitter_enable, .jitter_mode,
    .jitter_timer_use);
  peg_pwm_model i_pm (.mclk, .reset_n, .phw, .period_end, .second_drive_out,
    .phase_in);
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rq = avs_readdata;
    if (n >= 20)
      errors++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0);
    chk(nm, rq, e);
  endtask
  task automatic pe(input int k);
    repeat (k) @(posedge mclk iff period_end);
    repeat (4) @(posedge mclk);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    rd("period", `PEG_OFF_PERIOD, 32'hfff);
    rd("duty", `PEG_OFF_DUTY, 32'h7ff);
    rd("min phase", `PEG_OFF_MIN_PHASE, 32'h010);
    rd("unmapped", 6'h3c, 32'h0);
    $display("test reset done");
    comparator1_out <= 1'b1;
    pe(1);
    wr(`PEG_OFF_STATUS, 32'h3);
    pe(2);
    rd("masked no phase", `PEG_OFF_STATUS, 32'h0);
    comparator1_out <= 1'b0;
    pe(2);
    rd("no phase", `PEG_OFF_STATUS, 32'h1);
    phw <= 6'h14;
    pe(1);
    wr(`PEG_OFF_STATUS, 32'h3);
    pe(2);
    rd("long phase", `PEG_OFF_STATUS, 32'h0);
    phw <= 6'h04;
    pe(2);
    rd("short phase", `PEG_OFF_STATUS, 32'h2);
    phw <= 6'h14;
    pe(1);
    wr(`PEG_OFF_STATUS, 32'h3);
    $display("test phase done");
    wr(`PEG_OFF_ENABLES, 32'h6);
    wr(`PEG_OFF_ACTION, 32'h0);
    wr(`PEG_OFF_CTRL, 32'h19);
    comparator2_to_8_outs <= 7'h01;
    repeat (3) @(negedge mclk);
    chk("irq", error_guard_irq, 1'b1);
    chk("stop now", {generator_on, mask_select_a, mask_select_b,
      mask_level_a, mask_level_b}, 5'h0f);
    rd("forced off", `PEG_OFF_STATUS, 32'h14);
    comparator2_to_8_outs <= 7'h00;
    wr(`PEG_OFF_STATUS, 32'h4);
    wr(`PEG_OFF_CTRL, 32'h61);
    repeat (3) @(negedge mclk);
    chk("soft stop", generator_on, 1'b0);
    wr(`PEG_OFF_CTRL, 32'h0);
    wr(`PEG_OFF_ACTION, 32'h4);
    wr(`PEG_OFF_STATUS, 32'h4);
    wr(`PEG_OFF_CTRL, 32'h1);
    pe(1);
    comparator2_to_8_outs <= 7'h01;
    repeat (3) @(negedge mclk);
    chk("end stop wait", generator_on, 1'b1);
    pe(1);
    chk("end stop", generator_on, 1'b0);
    @(posedge mclk);
    comparator2_to_8_outs <= 7'h00;
    $display("test shutdown done");
    wr(`PEG_OFF_STATUS, 32'h4);
    wr(`PEG_OFF_PERIOD, 32'h64);
    wr(`PEG_OFF_DUTY, 32'h32);
    wr(`PEG_OFF_FLOOR, 32'h50);
    wr(`PEG_OFF_STEP, 32'h0a);
    wr(`PEG_OFF_ACTION, 32'hc);
    wr(`PEG_OFF_CTRL, 32'h1);
    comparator2_to_8_outs <= 7'h01;
    wr(`PEG_OFF_PERIOD, 32'h20);
    pe(4);
    rd("adjust period", `PEG_OFF_PERIOD, 32'h50);
    rd("adjust duty", `PEG_OFF_DUTY, 32'h28);
    rd("adjust flag", `PEG_OFF_STATUS, 32'h18);
    chk("adjust only", generator_on, 1'b1);
    comparator2_to_8_outs <= 7'h00;
    wr(`PEG_OFF_STATUS, 32'h0);
    wr(`PEG_OFF_PERIOD, 32'h64);
    wr(`PEG_OFF_DUTY, 32'h32);
    wr(`PEG_OFF_STEP, 32'h0b);
    wr(`PEG_OFF_ACTION, 32'h8);
    comparator2_to_8_outs <= 7'h01;
    pe(1);
    rd("odd step period", `PEG_OFF_PERIOD, 32'h59);
    rd("odd step duty", `PEG_OFF_DUTY, 32'h2d);
    chk("adjust running", generator_on, 1'b1);
    comparator2_to_8_outs <= 7'h03;
    repeat (3) @(negedge mclk);
    chk("pre-empt", {generator_on, period_value}, 13'h059);
    wr(`PEG_OFF_CTRL, 32'h100);
    repeat (2) @(negedge mclk);
    chk("jitter refused", jitter_enable, 1'b0);
    $display("test adjust done");
    @(posedge mclk);
    comparator2_to_8_outs <= 7'h00;
    wr(`PEG_OFF_STATUS, 32'h4);
    for (int i = 0; i < 5; i++) begin
      wr(`PEG_OFF_CTRL, {20'h0, i[2], i[0], i[2] | i[1], 9'h0});
      repeat (3) @(negedge mclk);
      chk("jitter mode", jitter_mode, i);
      chk("timer use", jitter_timer_use, i[2] | i[1]);
    end
    wr(`PEG_OFF_CTRL, 32'h100);
    repeat (2) @(negedge mclk);
    chk("jitter on", jitter_enable, 1'b1);
    $display("test jitter done");
    report_and_stop();
  end
endmodule

/* File: peg_pwm_model.sv */
`timescale 1ns/100ps
module peg_pwm_model (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [5:0] phw,
  output logic period_end,
  output logic second_drive_out,
  output logic phase_in
);
  logic [5:0] cnt;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n)
      cnt <= '0;
    else
      cnt <= (cnt == 6'h27) ? '0 : cnt + 6'h01;
  end
  // 40-cycle period, trigger output high in first half
  assign period_end = (cnt == 6'h27);
  assign second_drive_out = (cnt < 6'h14);
  // first phase pulse of phw cycles, then a stray short one
  assign phase_in = (cnt >= 6'h02 && cnt < phw + 6'h02)
    || (phw != '0 && cnt >= 6'h1e && cnt < 6'h20);
endmodule

/* File: peg_regs.svh */
`ifndef PEG_REGS_SVH
`define PEG_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PEG_OFF_CTRL 6'h00
`define PEG_OFF_STATUS 6'h04
`define PEG_OFF_ENABLES 6'h08
`define PEG_OFF_ACTION 6'h0c
`define PEG_OFF_PERIOD 6'h10
`define PEG_OFF_DUTY 6'h14
`define PEG_OFF_FLOOR 6'h18
`define PEG_OFF_STEP 6'h1c
`define PEG_OFF_MIN_PHASE 6'h20

// ---------------------------------------------------------------
// control register bits
// ---------------------------------------------------------------
`define PEG_CTRL_GEN_ON 0
`define PEG_CTRL_MASK_SEL_A 1
`define PEG_CTRL_MASK_SEL_B 2
`define PEG_CTRL_MASK_LVL_A 3
`define PEG_CTRL_MASK_LVL_B 4
`define PEG_CTRL_SOFT_BIT 5
`define PEG_CTRL_SOFT_EN 6
`define PEG_CTRL_FOLLOW 7
`define PEG_CTRL_JIT_EN 8
`define PEG_CTRL_JIT_HW 9
`define PEG_CTRL_JIT_METHOD 10
`define PEG_CTRL_JIT_SUB 11

// ---------------------------------------------------------------
// status register bits
// ---------------------------------------------------------------
`define PEG_ST_NO_PHASE 0
`define PEG_ST_SHORT_PHASE 1
`define PEG_ST_FORCED_OFF 2
`define PEG_ST_AUTO_ADJ 3
`define PEG_ST_IRQ 4
`define PEG_ST_BUSY 5

// ---------------------------------------------------------------
// sources, widths, reset values
// ---------------------------------------------------------------
`define PEG_NUM_SRC 9
`define PEG_ACT_W 24
`define PEG_FOLLOW_SRC_A 4'h1
`define PEG_FOLLOW_SRC_B 4'h3
`define PEG_PERIOD_W 12
`define PEG_PHASE_W 10
`define PEG_RST_PERIOD 12'hfff
`define PEG_RST_DUTY 12'h7ff
`define PEG_RST_MIN_PHASE 10'h010

`endif
